// file: gpp_pin_model.sv
// Far-side model of the pins and peripherals around the port block.
`timescale 1ns/1ps
module gpp_pin_model (
    // Clock.
    input wire logic mclk,
    // Levels the bench places on the far side.
    input wire logic [15:0] analog_level,
    input wire logic tx_level,
    // Port 8 drive from the block.
    input wire logic [1:0] port8_pin_out,
    input wire logic [1:0] port8_pin_oe_n,
    input wire logic [1:0] port8_pullup_on,
    // Levels seen by the block.
    output logic [15:0] analog_port_pins,
    output logic [1:0] port8_pin_in,
    output logic serial_transmit_line,
    output logic two_wire_data_out,
    output logic two_wire_clock_out
);
    logic churn = 1'b0;
    always @(posedge mclk) churn <= ~churn;
    // Port 7 pins are driven only from outside.
    assign analog_port_pins = analog_level;
    assign serial_transmit_line = tx_level;
    assign two_wire_data_out = 1'b1;
    assign two_wire_clock_out = 1'b1;
    // A released pin goes to its pull-up, or wanders so no stale level survives.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!port8_pin_oe_n[i]) port8_pin_in[i] = port8_pin_out[i];
            else if (port8_pullup_on[i]) port8_pin_in[i] = 1'b1;
            else port8_pin_in[i] = churn ^ i[0];
        end
    end
endmodule : gpp_pin_model

// file: gpp_pkg.sv
// Constants and types shared by the general-purpose port block.
package gpp_pkg;

    // Access size on the internal register bus.
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_BIT = 2'b01,
        SZ_HALF = 2'b10
    } gpp_size_type;

    // Register byte addresses.
    localparam logic [31:0] ADDR_PU6_LOW = 32'h0FFF_FC4C;
    localparam logic [31:0] ADDR_PU6_HIGH = 32'h0FFF_FC4D;
    localparam logic [31:0] ADDR_P7_LOW = 32'hFFFF_F40E;
    localparam logic [31:0] ADDR_P7_HIGH = 32'hFFFF_F40F;
    localparam logic [31:0] ADDR_P8_DATA = 32'hFFFF_F410;
    localparam logic [31:0] ADDR_P8_DIR = 32'hFFFF_F430;
    localparam logic [31:0] ADDR_P8_MODE = 32'hFFFF_F450;
    localparam logic [31:0] ADDR_P8_ALT = 32'hFFFF_F470;
    localparam logic [31:0] ADDR_P8_OD = 32'h0FFF_FC70;
    localparam logic [31:0] ADDR_P8_PU = 32'h0FFF_FC50;
    localparam logic [31:0] ADDR_ALT6_UP = 32'hFFFF_F46D;

    // Field positions and implemented-bit masks.
    localparam int PIN13_SEL_BIT = 5;
    localparam logic [7:0] ALT6_MASK = 8'h20;
    localparam logic [15:0] PU6_BASE_MASK = 16'h3FFF;
    localparam logic [15:0] PU6_ROM_MASK = 16'hC000;
    localparam logic [7:0] P8_MASK = 8'h03;

    // Values after reset.
    localparam logic [7:0] ALT6_RESET = 8'h00;
    localparam logic [15:0] PU6_RESET = 16'h0000;
    localparam logic [1:0] P8_DATA_RESET = 2'b00;
    localparam logic [1:0] P8_DIR_RESET = 2'b11;
    localparam logic [1:0] P8_CTRL_RESET = 2'b00;

    // Synchroniser depth for pin inputs.
    localparam int SYNC_STAGES = 2;

endpackage : gpp_pkg

// file: gpp_port.sv
// Port 6 upper select and pull-ups, input-only port 7, and two-pin port 8.
`timescale 1ns/1ps

module gpp_port
    import gpp_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter bit MASK_ROM_VARIANT = 1'b1,
    parameter bit TWO_WIRE_PRESENT = 1'b1
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Internal register bus.
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic [31:0] bus_addr,
    input wire gpp_size_type bus_size,
    input wire logic [2:0] bus_bitpos,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_ack,
    // Port 6 controls.
    output logic pin13_ctrl_direction,
    output logic [15:0] port6_pullup_enable,
    // Port 7 analog-shared input pins.
    input wire logic [15:0] analog_port_pins,
    // Port 8 pins.
    input wire logic [1:0] port8_pin_in,
    output logic [1:0] port8_pin_out,
    output logic [1:0] port8_pin_oe_n,
    output logic [1:0] port8_pullup_on,
    // Serial and two-wire peripherals.
    input wire logic serial_transmit_line,
    input wire logic two_wire_data_out,
    input wire logic two_wire_clock_out,
    output logic serial_receive_line,
    output logic two_wire_data_in,
    output logic two_wire_clock_in
);

    typedef struct packed {
        logic [7:0] alt6;
        logic [15:0] pu6;
        logic [1:0] p8_data;
        logic [1:0] p8_dir;
        logic [1:0] p8_mode;
        logic [1:0] p8_od;
        logic [1:0] p8_alt;
        logic [1:0] p8_pu;
        logic [15:0] rdata;
        logic ack;
    } gpp_port_state_type;

    // Implemented bits depend on the variant.
    localparam logic [15:0] PU6_MASK = PU6_BASE_MASK
        | (MASK_ROM_VARIANT ? PU6_ROM_MASK : 16'h0000);
    localparam logic [15:0] P7_MASK = LARGE_VARIANT ? 16'hFFFF : 16'h00FF;
    localparam logic [7:0] P8_IMPL = LARGE_VARIANT ? P8_MASK : 8'h00;
    localparam logic [7:0] P8_ALT_IMPL = TWO_WIRE_PRESENT ? P8_IMPL : 8'h00;

    gpp_port_state_type state;
    gpp_port_state_type next_state;

    gpp_sync_if #(.WIDTH(18)) pin_link ();
    logic [15:0] p7_level;
    logic [1:0] p8_level;

    assign pin_link.raw = {port8_pin_in, analog_port_pins};

    gpp_sync #(
        .WIDTH(18)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .link(pin_link)
    );

    // Port 7 is only ever read.
    assign p7_level = pin_link.synced[15:0] & P7_MASK;
    assign p8_level = pin_link.synced[17:16];

    // Byte or single-bit write merge, kept to the implemented bits.
    function automatic logic [7:0] merge_byte(
        input logic [7:0] old_val,
        input gpp_size_type size,
        input logic [2:0] pos,
        input logic [7:0] wdat,
        input logic [7:0] mask
    );
        logic [7:0] res;
        res = old_val;
        if (size == SZ_BIT) begin
            res[pos] = wdat[0];
        end else begin
            res = wdat;
        end
        return res & mask;
    endfunction : merge_byte

    logic wr_byte;
    logic wr_half;
    logic rd_byte;
    logic rd_half;
    logic [7:0] p8_read;

    assign wr_byte = bus_sel && bus_wr && (bus_size != SZ_HALF);
    assign wr_half = bus_sel && bus_wr && (bus_size == SZ_HALF);
    assign rd_byte = bus_sel && !bus_wr && (bus_size != SZ_HALF);
    assign rd_half = bus_sel && !bus_wr && (bus_size == SZ_HALF);

    // Output mode reads the latch, input mode reads the pin.
    assign p8_read = {6'h00, (state.p8_data & ~state.p8_dir) | (p8_level & state.p8_dir)} & P8_IMPL;

    always_comb begin
        logic [7:0] merged;
        merged = 8'h00;
        next_state = state;
        next_state.ack = bus_sel;
        next_state.rdata = 16'h0000;
        // Upper select byte and bit writes.
        if (wr_byte && bus_addr == ADDR_ALT6_UP) begin
            next_state.alt6 = merge_byte(state.alt6, bus_size, bus_bitpos, bus_wdata[7:0],
                ALT6_MASK);
        end
        if (wr_half && bus_addr == ADDR_PU6_LOW) begin
            next_state.pu6 = bus_wdata & PU6_MASK;
        end
        if (wr_byte && bus_addr == ADDR_PU6_LOW) begin
            next_state.pu6[7:0] = merge_byte(state.pu6[7:0], bus_size, bus_bitpos,
                bus_wdata[7:0], PU6_MASK[7:0]);
        end
        // High byte maps onto bits 8 to 15.
        if (wr_byte && bus_addr == ADDR_PU6_HIGH) begin
            next_state.pu6[15:8] = merge_byte(state.pu6[15:8], bus_size, bus_bitpos,
                bus_wdata[7:0], PU6_MASK[15:8]);
        end
        if (wr_byte) begin
            case (bus_addr)
                ADDR_P8_DATA: begin
                    merged = merge_byte({6'h00, state.p8_data}, bus_size, bus_bitpos,
                        bus_wdata[7:0], P8_IMPL);
                    next_state.p8_data = merged[1:0];
                end
                ADDR_P8_DIR: begin
                    merged = merge_byte({6'h00, state.p8_dir}, bus_size, bus_bitpos,
                        bus_wdata[7:0], P8_IMPL);
                    next_state.p8_dir = merged[1:0] | ~P8_IMPL[1:0];
                end
                ADDR_P8_MODE: begin
                    merged = merge_byte({6'h00, state.p8_mode}, bus_size, bus_bitpos,
                        bus_wdata[7:0], P8_IMPL);
                    next_state.p8_mode = merged[1:0];
                end
                ADDR_P8_OD: begin
                    merged = merge_byte({6'h00, state.p8_od}, bus_size, bus_bitpos,
                        bus_wdata[7:0], P8_IMPL);
                    next_state.p8_od = merged[1:0];
                end
                ADDR_P8_ALT: begin
                    merged = merge_byte({6'h00, state.p8_alt}, bus_size, bus_bitpos,
                        bus_wdata[7:0], P8_ALT_IMPL);
                    next_state.p8_alt = merged[1:0];
                end
                ADDR_P8_PU: begin
                    merged = merge_byte({6'h00, state.p8_pu}, bus_size, bus_bitpos,
                        bus_wdata[7:0], P8_IMPL);
                    next_state.p8_pu = merged[1:0];
                end
                default: next_state.p8_pu = state.p8_pu;
            endcase
        end
        // Halfword reads of pull-ups and, on the large variant, port 7.
        if (rd_half) begin
            if (bus_addr == ADDR_PU6_LOW) begin
                next_state.rdata = state.pu6;
            end else if (LARGE_VARIANT && bus_addr == ADDR_P7_LOW) begin
                next_state.rdata = p7_level;
            end
        end
        // Byte reads; the high port 7 byte exists only on the large variant.
        if (rd_byte) begin
            case (bus_addr)
                ADDR_ALT6_UP: next_state.rdata = {8'h00, state.alt6};
                ADDR_PU6_LOW: next_state.rdata = {8'h00, state.pu6[7:0]};
                ADDR_PU6_HIGH: next_state.rdata = {8'h00, state.pu6[15:8]};
                ADDR_P7_LOW: next_state.rdata = {8'h00, p7_level[7:0]};
                ADDR_P7_HIGH: next_state.rdata = {8'h00, p7_level[15:8]};
                ADDR_P8_DATA: next_state.rdata = {8'h00, p8_read};
                ADDR_P8_DIR: next_state.rdata = {14'h0000, state.p8_dir & P8_IMPL[1:0]};
                ADDR_P8_MODE: next_state.rdata = {14'h0000, state.p8_mode};
                ADDR_P8_OD: next_state.rdata = {14'h0000, state.p8_od};
                ADDR_P8_ALT: next_state.rdata = {14'h0000, state.p8_alt};
                ADDR_P8_PU: next_state.rdata = {14'h0000, state.p8_pu};
                default: next_state.rdata = 16'h0000;
            endcase
            // A single-bit read returns the chosen bit in bit 0.
            if (bus_size == SZ_BIT) begin
                next_state.rdata = {15'h0000, next_state.rdata[bus_bitpos]};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= '{alt6: ALT6_RESET, pu6: PU6_RESET, p8_data: P8_DATA_RESET,
                p8_dir: P8_DIR_RESET, p8_mode: P8_CTRL_RESET, p8_od: P8_CTRL_RESET,
                p8_alt: P8_CTRL_RESET, p8_pu: P8_CTRL_RESET, rdata: 16'h0000, ack: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign bus_rdata = state.rdata;
    assign bus_ack = state.ack;
    // Zero selects capture input, one timer output.
    assign pin13_ctrl_direction = state.alt6[PIN13_SEL_BIT];
    // Enable bits drive the pull-up switches.
    assign port6_pullup_enable = state.pu6;
    assign port8_pullup_on = state.p8_pu;

    // Alternate inputs from the synchronised pins.
    assign serial_receive_line = p8_level[0];
    assign two_wire_data_in = p8_level[0];
    assign two_wire_clock_in = p8_level[1];

    // Per-pin port or alternate drive with open-drain release.
    for (genvar i = 0; i < 2; i++) begin : g_p8_pin
        logic drive;
        logic value;
        always_comb begin
            if (!state.p8_mode[i]) begin
                drive = !state.p8_dir[i];
                value = state.p8_data[i];
            end else if (i == 0) begin
                drive = state.p8_alt[0];
                value = two_wire_data_out;
            end else begin
                drive = 1'b1;
                value = state.p8_alt[1] ? two_wire_clock_out : serial_transmit_line;
            end
            drive = drive && P8_IMPL[i];
        end
        assign port8_pin_out[i] = value;
        assign port8_pin_oe_n[i] = !(drive && !(state.p8_od[i] && value));
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_byte_write(logic [31:0] a);
        bus_sel && bus_wr && bus_size == SZ_BYTE && bus_addr == a;
    endsequence

    sequence s_byte_read(logic [31:0] a);
        bus_sel && !bus_wr && bus_size == SZ_BYTE && bus_addr == a;
    endsequence

    sequence s_half_read(logic [31:0] a);
        bus_sel && !bus_wr && bus_size == SZ_HALF && bus_addr == a;
    endsequence

    a_alt_write_lands: assert property (
        s_byte_write(ADDR_ALT6_UP) |=> pin13_ctrl_direction == $past(bus_wdata[5]))
        else $error("pin 13 select did not follow write");
    a_alt_other_zero: assert property (
        s_byte_read(ADDR_ALT6_UP) |=> bus_ack
        && bus_rdata[7:0] == {2'b00, pin13_ctrl_direction, 5'b00000})
        else $error("upper select read wrong");
    a_pu6_half_write: assert property (
        bus_sel && bus_wr && bus_size == SZ_HALF && bus_addr == ADDR_PU6_LOW
        |=> port6_pullup_enable == ($past(bus_wdata) & PU6_MASK))
        else $error("pull-up halfword write lost");
    a_pu6_high_byte: assert property (
        s_byte_write(ADDR_PU6_HIGH) |=> port6_pullup_enable[15:8] == ($past(bus_wdata[7:0])
        & PU6_MASK[15:8]) && $stable(port6_pullup_enable[7:0]))
        else $error("pull-up high byte misplaced");
    a_pu6_bit_write: assert property (
        bus_sel && bus_wr && bus_size == SZ_BIT && bus_addr == ADDR_PU6_LOW
        |=> port6_pullup_enable[$past(bus_bitpos)] == $past(bus_wdata[0]))
        else $error("pull-up bit write lost");
    a_pu6_rom_bits: assert property (
        (port6_pullup_enable & ~PU6_MASK) == 16'h0000)
        else $error("pull-up set on absent pin");
    a_p7_read_level: assert property (
        s_half_read(ADDR_P7_LOW) |=> bus_ack
        && bus_rdata == (LARGE_VARIANT ? $past(p7_level) : 16'h0000))
        else $error("port 7 read wrong");
    a_p7_small_width: assert property (
        LARGE_VARIANT || p7_level[15:8] == 8'h00)
        else $error("port 7 upper pins present on small variant");
    a_p8_port_drive: assert property (
        LARGE_VARIANT && !state.p8_mode[0] && !state.p8_dir[0] && !state.p8_od[0]
        |-> !port8_pin_oe_n[0] && port8_pin_out[0] == state.p8_data[0])
        else $error("port 8 pin 0 not driven from latch");
    a_p8_open_drain: assert property (
        state.p8_od[1] && port8_pin_out[1] |-> port8_pin_oe_n[1])
        else $error("open-drain pin drove high");

endmodule : gpp_port

// file: gpp_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module gpp_sync
    import gpp_pkg::*;
#(
    parameter int WIDTH = 18
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Pin levels in, synchronised levels out.
    gpp_sync_if.snk link
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } gpp_sync_state_type;

    gpp_sync_state_type state;
    gpp_sync_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.stage1 = link.raw;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign link.synced = state.stage2;

endmodule : gpp_sync

// file: gpp_sync_if.sv
// Carrier between raw pin levels and their synchronised copies.
`timescale 1ns/1ps
interface gpp_sync_if #(
    parameter int WIDTH = 18
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport src (
        output raw,
        input synced
    );
    modport snk (
        input raw,
        output synced
    );
endinterface : gpp_sync_if

// file: testbench.sv
// Self-checking testbench for the general-purpose port block.
`timescale 1ns/1ps
module testbench
    import gpp_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic bus_sel = 1'b0;
    logic bus_wr = 1'b0;
    logic [31:0] bus_addr = 32'h0000_0000;
    gpp_size_type bus_size = SZ_BYTE;
    logic [2:0] bus_bitpos = 3'h0;
    logic [15:0] bus_wdata = 16'h0000;
    logic [15:0] bus_rdata;
    logic bus_ack;
    logic pin13_ctrl_direction;
    logic [15:0] port6_pullup_enable;
    logic [15:0] analog_level = 16'h0000;
    logic tx_level = 1'b1;
    logic [15:0] analog_port_pins;
    logic [1:0] port8_pin_in, port8_pin_out, port8_pin_oe_n, port8_pullup_on;
    logic serial_transmit_line, two_wire_data_out, two_wire_clock_out;
    logic serial_receive_line, two_wire_clock_in;
    int fail_count = 0;
    int compares = 0;

    always #2 mclk = ~mclk;

    gpp_port gpp_port_inst (.mclk(mclk), .rst(rst), .bus_sel(bus_sel), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_size(bus_size), .bus_bitpos(bus_bitpos),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
        .pin13_ctrl_direction(pin13_ctrl_direction), .port6_pullup_enable(port6_pullup_enable),
        .analog_port_pins(analog_port_pins), .port8_pin_in(port8_pin_in),
        .port8_pin_out(port8_pin_out), .port8_pin_oe_n(port8_pin_oe_n),
        .port8_pullup_on(port8_pullup_on), .serial_transmit_line(serial_transmit_line),
        .two_wire_data_out(two_wire_data_out), .two_wire_clock_out(two_wire_clock_out),
        .serial_receive_line(serial_receive_line), .two_wire_data_in(),
        .two_wire_clock_in(two_wire_clock_in));

    gpp_pin_model gpp_pin_model_inst (.mclk(mclk), .analog_level(analog_level),
        .tx_level(tx_level), .port8_pin_out(port8_pin_out), .port8_pin_oe_n(port8_pin_oe_n),
        .port8_pullup_on(port8_pullup_on), .analog_port_pins(analog_port_pins),
        .port8_pin_in(port8_pin_in), .serial_transmit_line(serial_transmit_line),
        .two_wire_data_out(two_wire_data_out), .two_wire_clock_out(two_wire_clock_out));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One access: request held for exactly one taking edge, answer read 1 ns after that edge once bus_ack is high.
    task automatic access(input logic wr, input logic [31:0] addr, input gpp_size_type size,
        input logic [2:0] pos, input logic [15:0] wdata, output logic [15:0] rdata);
        int n;
        @(posedge mclk);
        bus_sel <= 1'b1;
        bus_wr <= wr;
        bus_addr <= addr;
        bus_size <= size;
        bus_bitpos <= pos;
        bus_wdata <= wdata;
        @(posedge mclk);
        bus_sel <= 1'b0;
        #1;
        n = 0;
        while (bus_ack !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (bus_ack !== 1'b1) begin
            fail_count++;
            $display("unexpected bus_ack expected 1 seen %b", bus_ack);
            end_of_test();
        end
        rdata = bus_rdata;
    endtask : access

    task automatic wr(input logic [31:0] a, input gpp_size_type s, input logic [2:0] p,
        input logic [15:0] d);
        logic [15:0] r;
        access(1'b1, a, s, p, d, r);
    endtask : wr

    task automatic rd(input logic [31:0] a, input gpp_size_type s, input logic [2:0] p,
        input logic [15:0] exp, input string what);
        logic [15:0] r;
        access(1'b0, a, s, p, 16'h0000, r);
        check(what, exp, r);
    endtask : rd

    task automatic test_reset();
        rd(ADDR_ALT6_UP, SZ_BYTE, 3'h0, 16'h0000, "alt select");
        rd(ADDR_PU6_LOW, SZ_HALF, 3'h0, 16'h0000, "pullup half");
        check("pin13 dir", 16'h0000, {15'h0000, pin13_ctrl_direction});
        check("pullup pins", 16'h0000, port6_pullup_enable);
        $display("test reset done");
    endtask : test_reset

    task automatic test_alt6();
        wr(ADDR_ALT6_UP, SZ_BYTE, 3'h0, 16'h00FF);
        rd(ADDR_ALT6_UP, SZ_BYTE, 3'h0, 16'h0020, "alt select");
        check("pin13 dir", 16'h0001, {15'h0000, pin13_ctrl_direction});
        wr(ADDR_ALT6_UP, SZ_BIT, 3'h5, 16'h0000);
        check("pin13 dir", 16'h0000, {15'h0000, pin13_ctrl_direction});
        wr(ADDR_ALT6_UP, SZ_BIT, 3'h4, 16'h0001);
        rd(ADDR_ALT6_UP, SZ_BYTE, 3'h0, 16'h0000, "alt select");
        $display("test alt select done");
    endtask : test_alt6

    task automatic test_pullup();
        wr(ADDR_PU6_LOW, SZ_HALF, 3'h0, 16'hFFFF);
        rd(ADDR_PU6_LOW, SZ_HALF, 3'h0, 16'hFFFF, "pullup half");
        check("pullup pins", 16'hFFFF, port6_pullup_enable);
        wr(ADDR_PU6_HIGH, SZ_BYTE, 3'h0, 16'h0012);
        check("pullup pins", 16'h12FF, port6_pullup_enable);
        wr(ADDR_PU6_LOW, SZ_BIT, 3'h0, 16'h0000);
        rd(ADDR_PU6_LOW, SZ_HALF, 3'h0, 16'h12FE, "pullup half");
        rd(ADDR_PU6_HIGH, SZ_BIT, 3'h1, 16'h0001, "pullup bit");
        rd(ADDR_PU6_LOW, SZ_BYTE, 3'h0, 16'h00FE, "pullup low");
        wr(ADDR_PU6_HIGH, SZ_HALF, 3'h0, 16'h0000);
        check("pullup pins", 16'h12FE, port6_pullup_enable);
        $display("test pullup done");
    endtask : test_pullup

    task automatic test_port7();
        analog_level <= 16'hA5C3;
        repeat (4) @(posedge mclk);
        rd(ADDR_P7_LOW, SZ_HALF, 3'h0, 16'hA5C3, "port7 half");
        rd(ADDR_P7_LOW, SZ_BYTE, 3'h0, 16'h00C3, "port7 low");
        rd(ADDR_P7_HIGH, SZ_BYTE, 3'h0, 16'h00A5, "port7 high");
        wr(ADDR_P7_LOW, SZ_HALF, 3'h0, 16'h0000);
        rd(ADDR_P7_LOW, SZ_HALF, 3'h0, 16'hA5C3, "port7 half");
        analog_level <= 16'h5A3C;
        repeat (4) @(posedge mclk);
        rd(ADDR_P7_LOW, SZ_HALF, 3'h0, 16'h5A3C, "port7 half");
        $display("test port7 done");
    endtask : test_port7

    task automatic test_port8();
        wr(ADDR_P8_PU, SZ_BYTE, 3'h0, 16'h0002);
        wr(ADDR_P8_DATA, SZ_BYTE, 3'h0, 16'h0003);
        wr(ADDR_P8_DIR, SZ_BYTE, 3'h0, 16'h0002);
        check("port8 oe_n", 16'h0002, {14'h0000, port8_pin_oe_n});
        check("port8 out0", 16'h0001, {15'h0000, port8_pin_out[0]});
        rd(ADDR_P8_DATA, SZ_BYTE, 3'h0, 16'h0003, "port8 data");
        check("receive line", 16'h0001, {15'h0000, serial_receive_line});
        check("two-wire clock in", 16'h0001, {15'h0000, two_wire_clock_in});
        check("port8 pullups", 16'h0002, {14'h0000, port8_pullup_on});
        wr(ADDR_P8_ALT, SZ_BIT, 3'h1, 16'h0000);
        wr(ADDR_P8_OD, SZ_BIT, 3'h1, 16'h0001);
        wr(ADDR_P8_DIR, SZ_BIT, 3'h1, 16'h0000);
        wr(ADDR_P8_MODE, SZ_BIT, 3'h1, 16'h0001);
        @(posedge mclk);
        tx_level <= 1'b0;
        #1;
        check("pin1 oe_n tx0", 16'h0000, {15'h0000, port8_pin_oe_n[1]});
        check("pin1 out tx0", 16'h0000, {15'h0000, port8_pin_out[1]});
        @(posedge mclk);
        tx_level <= 1'b1;
        #1;
        check("pin1 oe_n tx1", 16'h0001, {15'h0000, port8_pin_oe_n[1]});
        wr(ADDR_P8_DATA, SZ_BIT, 3'h1, 16'h0000);
        check("pin1 oe_n alt", 16'h0001, {15'h0000, port8_pin_oe_n[1]});
        wr(ADDR_P8_MODE, SZ_BIT, 3'h1, 16'h0000);
        check("pin1 oe_n port", 16'h0000, {15'h0000, port8_pin_oe_n[1]});
        $display("test port8 done");
    endtask : test_port8

    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        test_reset();
        test_alt6();
        test_pullup();
        test_port7();
        test_port8();
        end_of_test();
    end
endmodule : testbench
